// ### design/pfq_qualifier.sv
// design: per-port frame pass qualifier with ahb-lite register slave
`timescale 1ns/1ps
module pfq_qualifier #(
    parameter int WDOG_LIMIT_INIT = 24'd1_000_000
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        rx_lock,
    input  wire logic        rx_parity_err,
    input  wire logic        frame_valid,
    input  wire logic        line_valid,
    input  wire logic        pkt_in_valid,
    input  wire logic [31:0] pkt_in_data,
    output logic             pkt_out_valid,
    output logic      [31:0] pkt_out_data,
    output logic             port_qualified,
    output logic             irq
);
    import pfq_pkg::*;

    typedef enum logic [2:0] {
        PFQ_IDLE  = 3'b001,
        PFQ_COUNT = 3'b010,
        PFQ_PASS  = 3'b100
    } pfq_state_t;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic [7:0]         ctrl_q, ctrl_d;
    logic [31:0]        cfg_q, cfg_d;
    logic [IRQ_W-1:0]   irq_q, irq_d, mask_q, mask_d, ev;
    logic [31:0]        hrdata_q, hrdata_d;
    logic               wr_pend_q, wr_pend_d;
    logic [7:0]         wr_addr_q, wr_addr_d;
    logic               rd_clr_q, rd_clr_d;
    logic               irq_out_q;
    logic               acc;
    pfq_state_t         state_q, state_d;

    assign acc = hsel && hready && htrans[1];

    always_comb begin
        wr_pend_d = acc && hwrite;
        wr_addr_d = acc ? haddr[7:0] : wr_addr_q;
        rd_clr_d  = acc && !hwrite && (haddr[7:0] == ADDR_IRQ);
        hrdata_d  = hrdata_q;
        if (acc && !hwrite) begin
            case (haddr[7:0])
                ADDR_CTRL:   hrdata_d = {24'h000000, ctrl_q};
                ADDR_CFG:    hrdata_d = cfg_q;
                ADDR_STATUS: hrdata_d = {29'h0, state_q == PFQ_PASS,
                                         rx_lock, port_qualified};
                ADDR_IRQ:    hrdata_d = {27'h0, irq_q};
                ADDR_MASK:   hrdata_d = {27'h0, mask_q};
                default:     hrdata_d = 32'h0000_0000;
            endcase
        end
        ctrl_d = ctrl_q;
        cfg_d  = cfg_q;
        mask_d = mask_q;
        if (wr_pend_q) begin
            case (wr_addr_q)
                ADDR_CTRL: ctrl_d = hwdata[7:0] & CTRL_WR_MASK;
                ADDR_CFG:  cfg_d  = {31'h0, hwdata[CFG_FV_LEVEL_BIT]};
                ADDR_MASK: mask_d = hwdata[IRQ_W-1:0];
                default:   ctrl_d = ctrl_q;
            endcase
        end
        // read clears, but a new event in the same cycle survives
        irq_d = (rd_clr_q ? '0 : irq_q) | ev;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q    <= CTRL_RESET;
            cfg_q     <= CFG_RESET;
            mask_q    <= '0;
            irq_q     <= '0;
            hrdata_q  <= 32'h0000_0000;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rd_clr_q  <= 1'b0;
            irq_out_q <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            cfg_q     <= cfg_d;
            mask_q    <= mask_d;
            irq_q     <= irq_d;
            hrdata_q  <= hrdata_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rd_clr_q  <= rd_clr_d;
            irq_out_q <= |(irq_d & mask_d);
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = irq_out_q;

    // ------------------------------------------------------------
    // frame timing
    // ------------------------------------------------------------
    logic              fv_act, lv_act;
    logic              fv_q, lv_q;
    logic              frame_end, line_end;
    logic [LINE_W-1:0] line_len_q, line_len_d, last_len_q, last_len_d;
    logic [LINE_W-1:0] lines_q, lines_d, last_lines_q, last_lines_d;
    logic              len_known_q, len_known_d, lines_known_q;
    logic              lines_known_d;
    logic              size_chg, lines_chg;
    logic [CNT_W-1:0]  fcyc_q, fcyc_d, fper_q, fper_d, wd_q, wd_d;
    logic              wd_fire;

    assign fv_act    = frame_valid ^ cfg_q[CFG_FV_LEVEL_BIT];
    assign lv_act    = line_valid ^ cfg_q[CFG_FV_LEVEL_BIT];
    assign frame_end = fv_q && !fv_act;
    assign line_end  = lv_q && !lv_act;
    assign size_chg  = ctrl_q[CTRL_SIZE_BIT] && line_end && len_known_q
                       && (line_len_q != last_len_q);
    assign lines_chg = ctrl_q[CTRL_LINES_BIT] && frame_end && lines_known_q
                       && (lines_q != last_lines_q);

    always_comb begin
        line_len_d    = lv_act ? line_len_q + 1'b1 : '0;
        last_len_d    = line_end ? line_len_q : last_len_q;
        len_known_d   = (len_known_q || line_end) && rx_lock;
        lines_d       = frame_end ? '0
                      : (line_end ? lines_q + 1'b1 : lines_q);
        last_lines_d  = frame_end ? lines_q : last_lines_q;
        lines_known_d = (lines_known_q || frame_end) && rx_lock;
        fcyc_d        = frame_end ? '0 : fcyc_q + 1'b1;
        fper_d        = frame_end ? fcyc_q : fper_q;
        // watchdog window is two measured frame periods
        if (frame_end || !rx_lock)
            wd_d = '0;
        else
            wd_d = wd_q + 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fv_q          <= 1'b0;
            lv_q          <= 1'b0;
            line_len_q    <= '0;
            last_len_q    <= '0;
            len_known_q   <= 1'b0;
            lines_q       <= '0;
            last_lines_q  <= '0;
            lines_known_q <= 1'b0;
            fcyc_q        <= '0;
            fper_q        <= CNT_W'(WDOG_LIMIT_INIT);
            wd_q          <= '0;
        end else begin
            fv_q          <= fv_act;
            lv_q          <= lv_act;
            line_len_q    <= line_len_d;
            last_len_q    <= last_len_d;
            len_known_q   <= len_known_d;
            lines_q       <= lines_d;
            last_lines_q  <= last_lines_d;
            lines_known_q <= lines_known_d;
            fcyc_q        <= fcyc_d;
            fper_q        <= fper_d;
            wd_q          <= wd_d;
        end
    end

    assign wd_fire = !ctrl_q[CTRL_WDOG_BIT]
                     && (ctrl_q[CTRL_TGT_HI:0] != 2'b00)
                     && (wd_q >= {fper_q[CNT_W-2:0], 1'b0});

    // ------------------------------------------------------------
    // qualification state machine
    // ------------------------------------------------------------
    logic [1:0] good_q, good_d;
    logic       disq, frame_bad_q, frame_bad_d, qual_d, qual_q;
    logic       par_hold;

    assign par_hold = ctrl_q[CTRL_PAR_BIT];
    assign disq     = size_chg || lines_chg || wd_fire
                      || (rx_parity_err && par_hold);

    always_comb begin
        state_d     = state_q;
        good_d      = good_q;
        frame_bad_d = frame_bad_q || disq || rx_parity_err;
        if (frame_end)
            frame_bad_d = disq;
        case (state_q)
            PFQ_IDLE: begin
                good_d = 2'b00;
                if (rx_lock)
                    state_d = (ctrl_q[CTRL_TGT_HI:0] == 2'b00)
                              ? PFQ_PASS : PFQ_COUNT;
            end
            PFQ_COUNT: begin
                if (disq) begin
                    good_d = 2'b00;
                end else if (ctrl_q[CTRL_TGT_HI:0] == 2'b00) begin
                    state_d = PFQ_PASS;
                end else if (frame_end && !frame_bad_q) begin
                    good_d = good_q + 1'b1;
                    if (good_q + 1'b1 >= ctrl_q[CTRL_TGT_HI:0])
                        state_d = PFQ_PASS;
                end
            end
            PFQ_PASS: begin
                if (disq) begin
                    state_d = PFQ_COUNT;
                    good_d  = 2'b00;
                end
            end
            default: state_d = PFQ_IDLE;
        endcase
        if (!rx_lock) begin
            state_d = PFQ_IDLE;
            good_d  = 2'b00;
        end
        // momentary drop on parity error in non-hold mode
        qual_d = (state_d == PFQ_PASS)
                 && !(rx_parity_err && !par_hold);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q     <= PFQ_IDLE;
            good_q      <= 2'b00;
            frame_bad_q <= 1'b0;
            qual_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            good_q      <= good_d;
            frame_bad_q <= frame_bad_d;
            qual_q      <= qual_d;
        end
    end

    assign port_qualified = qual_q;

    always_comb begin
        ev               = '0;
        ev[EV_QUAL_UP]   = qual_d && !qual_q;
        ev[EV_QUAL_DOWN] = !qual_d && qual_q;
        ev[EV_PAR_ERR]   = rx_parity_err;
        ev[EV_WDOG]      = wd_fire;
        ev[EV_SIZE_CHG]  = size_chg || lines_chg;
    end

    // ------------------------------------------------------------
    // packet gating
    // ------------------------------------------------------------
    logic        pv_q;
    logic [31:0] pd_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pv_q <= 1'b0;
            pd_q <= 32'h0000_0000;
        end else begin
            pv_q <= pkt_in_valid
                    && (!ctrl_q[CTRL_DISCARD_BIT] || qual_q);
            pd_q <= pkt_in_data;
        end
    end

    assign pkt_out_valid = pv_q;
    assign pkt_out_data  = pd_q;
endmodule : pfq_qualifier

// ### dv/pfq_link_model.sv
// partner: link receiver frame timing and packet source
`timescale 1ns/1ps
module pfq_link_model (
    input  wire logic        hclk,
    input  wire logic        run,
    input  wire logic        fv_level,
    input  wire logic [3:0]  lines,
    input  wire logic [3:0]  llen,
    output logic             frame_valid,
    output logic             line_valid,
    output logic             pkt_in_valid,
    output logic      [31:0] pkt_in_data
);
    // ------------------------------------------------------------
    // raster counters, two blank cycles and two blank lines
    // ------------------------------------------------------------
    logic [3:0] x_q = 4'h0;
    logic [3:0] y_q = 4'h0;
    logic       act;
    logic [31:0] data_q = 32'h5a5a_0001;
    always_ff @(posedge hclk) begin
        data_q <= {data_q[30:0], ~data_q[31]};
        x_q <= (!run || x_q >= llen + 4'h1) ? 4'h0 : x_q + 4'h1;
        if (!run)
            y_q <= 4'h0;
        else if (x_q >= llen + 4'h1)
            y_q <= (y_q >= lines + 4'h1) ? 4'h0 : y_q + 4'h1;
    end
    assign act          = run && y_q < lines;
    assign pkt_in_data  = data_q;
    assign pkt_in_valid = act && x_q < llen;
    assign frame_valid  = act ^ fv_level;
    assign line_valid   = pkt_in_valid ^ fv_level;
endmodule : pfq_link_model

// ### dv/pfq_properties.sv
// checker: port properties of the pass qualifier
`timescale 1ns/1ps
module pfq_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        rx_lock,
    input wire logic        rx_parity_err,
    input wire logic        pkt_in_valid,
    input wire logic [31:0] pkt_in_data,
    input wire logic        pkt_out_valid,
    input wire logic [31:0] pkt_out_data,
    input wire logic        port_qualified
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_lock_low: assert property (!rx_lock |=> !port_qualified)
        else $error("qualified without lock");
    chk_lock_held: assert property (port_qualified |-> $past(rx_lock))
        else $error("qualified one cycle after lock loss");
    chk_reset_quiet: assert property ($rose(hresetn) |->
        !port_qualified && !pkt_out_valid)
        else $error("outputs active at reset release");
    chk_par_drop: assert property (rx_parity_err |=> !port_qualified)
        else $error("parity error left qualified high");
    chk_rise_cause: assert property ($rose(port_qualified) |->
        $past(rx_lock) && !$past(rx_parity_err))
        else $error("qualified rose without clean locked cycle");
    chk_fwd_qual: assert property (pkt_in_valid && port_qualified
        |=> pkt_out_valid)
        else $error("word dropped while qualified");
    chk_out_cause: assert property (pkt_out_valid |->
        $past(pkt_in_valid) && pkt_out_data == $past(pkt_in_data))
        else $error("output word without matching input");
    chk_nolock_pair: assert property (!rx_lock ##1 !rx_lock
        |-> !port_qualified)
        else $error("qualified during lock absence");
endmodule : pfq_checker

bind pfq_qualifier pfq_checker pfq_checker_i (.hclk, .hresetn, .rx_lock,
    .rx_parity_err, .pkt_in_valid, .pkt_in_data, .pkt_out_valid,
    .pkt_out_data, .port_qualified);

// ### dv/tb_port_frame_pass_qualifier.sv
// testbench: register and link scenarios for the pass qualifier
`timescale 1ns/1ps
module tb_port_frame_pass_qualifier;
    import pfq_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic        rx_lock, rx_parity_err, run, fv_level, port_qualified;
    logic        frame_valid, line_valid, pkt_in_valid, pkt_out_valid;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  lines, llen;
    logic [31:0] haddr, hwdata, hrdata, pkt_in_data, pkt_out_data, rd;
    int          errors, checked, cyc, outs;
    pfq_qualifier #(.WDOG_LIMIT_INIT(200)) pfq_qualifier_i (.hclk,
        .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_lock,
        .rx_parity_err, .frame_valid, .line_valid, .pkt_in_valid,
        .pkt_in_data, .pkt_out_valid, .pkt_out_data, .port_qualified, .irq);
    pfq_link_model pfq_link_model_i (.hclk, .run, .fv_level, .lines, .llen,
        .frame_valid, .line_valid, .pkt_in_valid, .pkt_in_data);
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic print_verdict;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic ahb(input logic [7:0] a, input logic w,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic wq(input logic v, input int n);
        for (int i = 0; i < n && port_qualified !== v; i++) @(negedge hclk);
        cmp({31'h0, port_qualified}, {31'h0, v});
        @(posedge hclk);
    endtask : wq
    task automatic hold(input logic v, input int n);
        int bad;
        bad = 0;
        outs = 0;
        repeat (n) begin
            @(negedge hclk);
            bad = bad + int'(port_qualified !== v);
            outs = outs + int'(pkt_out_valid === 1'b1);
        end
        cmp(bad, 0);
        @(posedge hclk);
    endtask : hold
    task automatic perr;
        rx_parity_err <= 1'b1;
        @(posedge hclk);
        rx_parity_err <= 1'b0;
        @(negedge hclk);
        cmp({31'h0, port_qualified}, 32'h0);
    endtask : perr
    // ------------------------------------------------------------
    // clock, timeout, sequence
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        {hsel, hwrite, rx_lock, rx_parity_err, run, fv_level} = 6'h0;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
        {hresetn, lines, llen, errors, checked, cyc} = {1'b0, 8'h46, 96'h0};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(ADDR_CTRL, 1'b0, 0); cmp(rd, {24'h0, CTRL_RESET});
        ahb(ADDR_CTRL, 1'b1, 32'hff);
        ahb(ADDR_CTRL, 1'b0, 0); cmp(rd, {24'h0, CTRL_WR_MASK});
        ahb(8'h20, 1'b0, 0); cmp(rd, 32'h0);
        cmp({31'h0, hresp}, 32'h0);
        $display("test registers done");
        ahb(ADDR_CTRL, 1'b1, 32'h80);
        run <= 1'b1;
        hold(1'b0, 100); cmp(outs, 0);
        ahb(ADDR_CTRL, 1'b1, 32'h00);
        hold(1'b0, 60); cmp(outs != 0, 1);
        rx_lock <= 1'b1;
        wq(1'b1, 4);
        run <= 1'b0;
        hold(1'b1, 400);
        $display("test discard and zero target done");
        rx_lock <= 1'b0;
        ahb(ADDR_IRQ, 1'b0, 0);
        ahb(ADDR_CTRL, 1'b1, 32'h02);
        rx_lock <= 1'b1;
        run <= 1'b1;
        hold(1'b0, 60); wq(1'b1, 60);
        cmp({31'h0, irq}, 32'h0);
        ahb(ADDR_MASK, 1'b1, 32'h1 << EV_QUAL_UP);
        @(negedge hclk); @(negedge hclk); cmp({31'h0, irq}, 32'h1);
        ahb(ADDR_IRQ, 1'b0, 0); cmp(rd, 32'h1 << EV_QUAL_UP);
        @(negedge hclk); @(negedge hclk); cmp({31'h0, irq}, 32'h0);
        $display("test frame target and interrupt done");
        ahb(ADDR_CTRL, 1'b1, 32'h22);
        lines <= 4'h5;
        wq(1'b0, 150); hold(1'b0, 40); wq(1'b1, 200);
        ahb(ADDR_CTRL, 1'b1, 32'h12);
        llen <= 4'h5;
        wq(1'b0, 150); hold(1'b0, 30); wq(1'b1, 200);
        $display("test line checks done");
        ahb(ADDR_CTRL, 1'b1, 32'h02);
        perr(); hold(1'b1, 20);
        ahb(ADDR_CTRL, 1'b1, 32'h0a);
        perr(); hold(1'b0, 30); wq(1'b1, 200);
        $display("test parity modes done");
        ahb(ADDR_CTRL, 1'b1, 32'h02);
        run <= 1'b0;
        hold(1'b1, 40); wq(1'b0, 200);
        ahb(ADDR_CTRL, 1'b1, 32'h06);
        run <= 1'b1;
        wq(1'b1, 200);
        run <= 1'b0;
        hold(1'b1, 300);
        $display("test watchdog done");
        rx_lock <= 1'b0;
        fv_level <= 1'b1;
        ahb(ADDR_CFG, 1'b1, 32'h1 << CFG_FV_LEVEL_BIT);
        ahb(ADDR_CTRL, 1'b1, 32'h02);
        rx_lock <= 1'b1;
        run <= 1'b1;
        hold(1'b0, 70); wq(1'b1, 60);
        $display("test frame level done");
        print_verdict();
    end
endmodule : tb_port_frame_pass_qualifier

// ### pkg/pfq_pkg.sv
// package: register map, field positions and timing for the pass qualifier
package pfq_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CFG    = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ    = 8'h0c;
    localparam logic [7:0] ADDR_MASK   = 8'h10;
    // ------------------------------------------------------------
    // control and config register fields
    // ------------------------------------------------------------
    localparam int CTRL_DISCARD_BIT = 7;
    localparam int CTRL_LINES_BIT   = 5;
    localparam int CTRL_SIZE_BIT    = 4;
    localparam int CTRL_PAR_BIT     = 3;
    localparam int CTRL_WDOG_BIT    = 2;
    localparam int CTRL_TGT_HI      = 1;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] CTRL_WR_MASK  = 8'hbf;
    localparam int CFG_FV_LEVEL_BIT = 0;
    localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
    // ------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------
    localparam int IRQ_W         = 5;
    localparam int EV_QUAL_UP    = 0;
    localparam int EV_QUAL_DOWN  = 1;
    localparam int EV_PAR_ERR    = 2;
    localparam int EV_WDOG       = 3;
    localparam int EV_SIZE_CHG   = 4;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int CNT_W         = 24;
    localparam int LINE_W        = 16;
endpackage : pfq_pkg
